/* rtl/jtag_tc_pkg.sv */
/*
  constants for the jtag test access port test controller: instruction codes,
  register widths, capture patterns and debug answer codes.
  assumes a 4-bit instruction register and a 32-bit debug data path.
*/
// Contract
// - tdi, tms, tck in; tdo only out
// - tms-driven state machine picks serial register
// - tdi shifts through selected register to tdo
// - capture copies selected register into shifter
// - update copies shifter into selected register
// - instruction register selects the data register
// - one-bit bypass register links tdi to tdo
// - 32-bit identification register readable serially
// - pin scan chain sets or reads pins
// - io pins each carry a scan cell
// - extest: test mode, sample pins, drive pins
// - sample: normal mode, capture functional data
// - preload: load chain in normal mode
// - idcode selects identification register
// - intest: chain reaches core logic signals
// - extra instructions reach rest of device
// - debug access port reaches memory and registers
// - host uses jtag or serial wire debug
// - serial wire debug on gpio or usb
// - jtag four/five wires, swd two wires
package jtag_tc_pkg;
  localparam int unsigned IR_W        = 4;
  localparam int unsigned ID_W        = 32;
  localparam int unsigned DBG_DATA_W  = 32;
  localparam int unsigned DBG_ADDR_W  = 2;
  localparam int unsigned DBG_ACK_W   = 3;
  localparam int unsigned DBG_DR_W    = DBG_DATA_W + DBG_ADDR_W + 1;
  localparam int unsigned CELL_W      = 3;

  localparam logic [IR_W-1:0] OP_EXTEST  = 4'h0;
  localparam logic [IR_W-1:0] OP_SAMPLE  = 4'h1;
  localparam logic [IR_W-1:0] OP_PRELOAD = 4'h2;
  localparam logic [IR_W-1:0] OP_INTEST  = 4'h3;
  localparam logic [IR_W-1:0] OP_DBG     = 4'h8;
  localparam logic [IR_W-1:0] OP_IDCODE  = 4'he;
  localparam logic [IR_W-1:0] OP_BYPASS  = 4'hf;

  localparam logic [IR_W-1:0] IR_RESET   = OP_IDCODE;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  localparam logic [DBG_ACK_W-1:0] ACK_OK   = 3'h2;
  localparam logic [DBG_ACK_W-1:0] ACK_WAIT = 3'h1;

  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UP_DR  = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UP_IR  = 16'h8000
  } tap_state_t;

  typedef enum logic [2:0] {
    DB_IDLE = 3'h1,
    DB_REQ  = 3'h2,
    DB_RSP  = 3'h4
  } dbg_state_t;
endpackage : jtag_tc_pkg

/* rtl/jtag_tap_test_controller.sv */
/*
  jtag test access port controller with pin scan chain, identification,
  bypass and a debug access port bridge into the core clock domain.
  assumes pads are asynchronous to both clocks; tck may stop between scans.
*/
module jtag_tap_test_controller #(
  parameter int unsigned     NUM_PINS = 8,
  parameter logic [31:0]     ID_VALUE = 32'h0000_0001  // arbitrary value
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  rstn,
  input  wire logic                                  tck,
  input  wire logic                                  tms,
  input  wire logic                                  tdi,
  input  wire logic                                  trst_n,
  output logic                                       tdo,
  output logic                                       tdo_oe,
  input  wire logic                                  swd_sel,
  input  wire logic                                  swd_usb_sel,
  output logic                                       swd_gpio_en,
  output logic                                       swd_usb_en,
  input  wire logic [NUM_PINS-1:0]                   pad_in,
  output logic      [NUM_PINS-1:0]                   pad_out,
  output logic      [NUM_PINS-1:0]                   pad_oe,
  input  wire logic [NUM_PINS-1:0]                   core_out,
  input  wire logic [NUM_PINS-1:0]                   core_oe,
  output logic      [NUM_PINS-1:0]                   core_in,
  output logic                                       test_mode,
  output logic                                       dbg_req_valid,
  input  wire logic                                  dbg_req_ready,
  output logic                                       dbg_rnw,
  output logic      [jtag_tc_pkg::DBG_ADDR_W-1:0]    dbg_addr,
  output logic      [jtag_tc_pkg::DBG_DATA_W-1:0]    dbg_wdata,
  input  wire logic                                  dbg_rsp_valid,
  input  wire logic [jtag_tc_pkg::DBG_DATA_W-1:0]    dbg_rdata
);
  localparam int unsigned CHAIN_W = NUM_PINS * jtag_tc_pkg::CELL_W;

  initial begin
    if (NUM_PINS < 1) begin
      $error("NUM_PINS must be at least one");
    end
    if (ID_VALUE[0] != 1'b1) begin
      $error("ID_VALUE bit 0 must be one");
    end
  end

  logic tck_rst_n;
  assign tck_rst_n = rstn & trst_n;

  // tck domain: swd select, pad and core output synchronisers
  logic                swd_s1_ff;
  logic                swd_s2_ff;
  logic [NUM_PINS-1:0] pad_s1_ff;
  logic [NUM_PINS-1:0] pad_s2_ff;
  logic [NUM_PINS-1:0] cout_s1_ff;
  logic [NUM_PINS-1:0] cout_s2_ff;
  logic [NUM_PINS-1:0] coe_s1_ff;
  logic [NUM_PINS-1:0] coe_s2_ff;

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      swd_s1_ff  <= 1'b0;
      swd_s2_ff  <= 1'b0;
      pad_s1_ff  <= '0;
      pad_s2_ff  <= '0;
      cout_s1_ff <= '0;
      cout_s2_ff <= '0;
      coe_s1_ff  <= '0;
      coe_s2_ff  <= '0;
    end else begin
      swd_s1_ff  <= swd_sel;
      swd_s2_ff  <= swd_s1_ff;
      pad_s1_ff  <= pad_in;
      pad_s2_ff  <= pad_s1_ff;
      cout_s1_ff <= core_out;
      cout_s2_ff <= cout_s1_ff;
      coe_s1_ff  <= core_oe;
      coe_s2_ff  <= coe_s1_ff;
    end
  end

  // tap state machine
  jtag_tc_pkg::tap_state_t state_ff;
  jtag_tc_pkg::tap_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      jtag_tc_pkg::ST_RESET:  nxt_state = tms ? jtag_tc_pkg::ST_RESET  : jtag_tc_pkg::ST_IDLE;
      jtag_tc_pkg::ST_IDLE:   nxt_state = tms ? jtag_tc_pkg::ST_SEL_DR : jtag_tc_pkg::ST_IDLE;
      jtag_tc_pkg::ST_SEL_DR: nxt_state = tms ? jtag_tc_pkg::ST_SEL_IR : jtag_tc_pkg::ST_CAP_DR;
      jtag_tc_pkg::ST_CAP_DR: nxt_state = tms ? jtag_tc_pkg::ST_EX1_DR : jtag_tc_pkg::ST_SH_DR;
      jtag_tc_pkg::ST_SH_DR:  nxt_state = tms ? jtag_tc_pkg::ST_EX1_DR : jtag_tc_pkg::ST_SH_DR;
      jtag_tc_pkg::ST_EX1_DR: nxt_state = tms ? jtag_tc_pkg::ST_UP_DR  : jtag_tc_pkg::ST_PA_DR;
      jtag_tc_pkg::ST_PA_DR:  nxt_state = tms ? jtag_tc_pkg::ST_EX2_DR : jtag_tc_pkg::ST_PA_DR;
      jtag_tc_pkg::ST_EX2_DR: nxt_state = tms ? jtag_tc_pkg::ST_UP_DR  : jtag_tc_pkg::ST_SH_DR;
      jtag_tc_pkg::ST_UP_DR:  nxt_state = tms ? jtag_tc_pkg::ST_SEL_DR : jtag_tc_pkg::ST_IDLE;
      jtag_tc_pkg::ST_SEL_IR: nxt_state = tms ? jtag_tc_pkg::ST_RESET  : jtag_tc_pkg::ST_CAP_IR;
      jtag_tc_pkg::ST_CAP_IR: nxt_state = tms ? jtag_tc_pkg::ST_EX1_IR : jtag_tc_pkg::ST_SH_IR;
      jtag_tc_pkg::ST_SH_IR:  nxt_state = tms ? jtag_tc_pkg::ST_EX1_IR : jtag_tc_pkg::ST_SH_IR;
      jtag_tc_pkg::ST_EX1_IR: nxt_state = tms ? jtag_tc_pkg::ST_UP_IR  : jtag_tc_pkg::ST_PA_IR;
      jtag_tc_pkg::ST_PA_IR:  nxt_state = tms ? jtag_tc_pkg::ST_EX2_IR : jtag_tc_pkg::ST_PA_IR;
      jtag_tc_pkg::ST_EX2_IR: nxt_state = tms ? jtag_tc_pkg::ST_UP_IR  : jtag_tc_pkg::ST_SH_IR;
      jtag_tc_pkg::ST_UP_IR:  nxt_state = tms ? jtag_tc_pkg::ST_SEL_DR : jtag_tc_pkg::ST_IDLE;
      default:                nxt_state = jtag_tc_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      state_ff <= jtag_tc_pkg::ST_RESET;
    end else if (swd_s2_ff) begin
      state_ff <= jtag_tc_pkg::ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  logic in_reset;
  logic cap_dr;
  logic sh_dr;
  logic up_dr;
  logic cap_ir;
  logic sh_ir;
  logic up_ir;
  assign in_reset = (state_ff == jtag_tc_pkg::ST_RESET);
  assign cap_dr   = (state_ff == jtag_tc_pkg::ST_CAP_DR);
  assign sh_dr    = (state_ff == jtag_tc_pkg::ST_SH_DR);
  assign up_dr    = (state_ff == jtag_tc_pkg::ST_UP_DR);
  assign cap_ir   = (state_ff == jtag_tc_pkg::ST_CAP_IR);
  assign sh_ir    = (state_ff == jtag_tc_pkg::ST_SH_IR);
  assign up_ir    = (state_ff == jtag_tc_pkg::ST_UP_IR);

  // instruction register
  logic [jtag_tc_pkg::IR_W-1:0] ir_sh_ff;
  logic [jtag_tc_pkg::IR_W-1:0] ir_ff;

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ir_sh_ff <= jtag_tc_pkg::IR_CAPTURE;
    end else if (cap_ir) begin
      ir_sh_ff <= jtag_tc_pkg::IR_CAPTURE;
    end else if (sh_ir) begin
      ir_sh_ff <= {tdi, ir_sh_ff[jtag_tc_pkg::IR_W-1:1]};
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ir_ff <= jtag_tc_pkg::IR_RESET;
    end else if (in_reset) begin
      ir_ff <= jtag_tc_pkg::IR_RESET;
    end else if (up_ir) begin
      ir_ff <= ir_sh_ff;
    end
  end

  // data register selection
  logic sel_chain;
  logic sel_id;
  logic sel_dbg;
  logic sel_byp;
  logic is_extest;
  logic is_intest;
  assign is_extest = (ir_ff == jtag_tc_pkg::OP_EXTEST);
  assign is_intest = (ir_ff == jtag_tc_pkg::OP_INTEST);
  assign sel_chain = is_extest | is_intest
                   | (ir_ff == jtag_tc_pkg::OP_SAMPLE)
                   | (ir_ff == jtag_tc_pkg::OP_PRELOAD);
  assign sel_id    = (ir_ff == jtag_tc_pkg::OP_IDCODE);
  assign sel_dbg   = (ir_ff == jtag_tc_pkg::OP_DBG);
  assign sel_byp   = ~(sel_chain | sel_id | sel_dbg);

  // bypass and identification shifters
  logic                       byp_ff;
  logic [jtag_tc_pkg::ID_W-1:0] id_sh_ff;

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      byp_ff <= 1'b0;
    end else if (cap_dr && sel_byp) begin
      byp_ff <= 1'b0;
    end else if (sh_dr && sel_byp) begin
      byp_ff <= tdi;
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      id_sh_ff <= '0;
    end else if (cap_dr && sel_id) begin
      id_sh_ff <= ID_VALUE;
    end else if (sh_dr && sel_id) begin
      id_sh_ff <= {tdi, id_sh_ff[jtag_tc_pkg::ID_W-1:1]};
    end
  end

  // pin scan chain: per pin {oe, out, in}
  logic [CHAIN_W-1:0] chain_sh_ff;
  logic [CHAIN_W-1:0] chain_up_ff;
  logic [CHAIN_W-1:0] chain_cap;

  always_comb begin
    chain_cap = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      chain_cap[i*jtag_tc_pkg::CELL_W]     = is_intest ? 1'b0 : pad_s2_ff[i];
      chain_cap[i*jtag_tc_pkg::CELL_W + 1] = cout_s2_ff[i];
      chain_cap[i*jtag_tc_pkg::CELL_W + 2] = coe_s2_ff[i];
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      chain_sh_ff <= '0;
    end else if (cap_dr && sel_chain) begin
      chain_sh_ff <= chain_cap;
    end else if (sh_dr && sel_chain) begin
      chain_sh_ff <= {tdi, chain_sh_ff[CHAIN_W-1:1]};
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      chain_up_ff <= '0;
    end else if (up_dr && sel_chain) begin
      chain_up_ff <= chain_sh_ff;
    end
  end

  // test mode latches with the instruction; normal after reset
  assign test_mode = is_extest | is_intest;

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pad_out[i] = is_extest ? chain_up_ff[i*jtag_tc_pkg::CELL_W + 1] : core_out[i];
      pad_oe[i]  = is_extest ? chain_up_ff[i*jtag_tc_pkg::CELL_W + 2] : core_oe[i];
      core_in[i] = is_intest ? chain_up_ff[i*jtag_tc_pkg::CELL_W] : pad_in[i];
    end
  end

  // debug data register and request toggle
  logic [jtag_tc_pkg::DBG_DR_W-1:0]   dbg_sh_ff;
  logic [jtag_tc_pkg::DBG_DR_W-1:0]   dbg_hold_ff;
  logic                               req_tgl_ff;
  logic                               ack_s1_ff;
  logic                               ack_s2_ff;
  logic                               dbg_busy;
  logic [jtag_tc_pkg::DBG_ACK_W-1:0]  dbg_ack;
  logic [jtag_tc_pkg::DBG_DATA_W-1:0] rsp_data_ff;
  logic                               ack_tgl_ff;

  assign dbg_busy = req_tgl_ff ^ ack_s2_ff;
  assign dbg_ack  = dbg_busy ? jtag_tc_pkg::ACK_WAIT : jtag_tc_pkg::ACK_OK;

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      dbg_sh_ff <= '0;
    end else if (cap_dr && sel_dbg) begin
      dbg_sh_ff <= dbg_busy ? {dbg_ack, {jtag_tc_pkg::DBG_DATA_W{1'b0}}}
                            : {dbg_ack, rsp_data_ff};
    end else if (sh_dr && sel_dbg) begin
      dbg_sh_ff <= {tdi, dbg_sh_ff[jtag_tc_pkg::DBG_DR_W-1:1]};
    end
  end

  // a request while busy is dropped; hold stays stable until ack
  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      dbg_hold_ff <= '0;
      req_tgl_ff  <= 1'b0;
    end else if (up_dr && sel_dbg && !dbg_busy) begin
      dbg_hold_ff <= dbg_sh_ff;
      req_tgl_ff  <= ~req_tgl_ff;
    end
  end

  // tdo on falling edge, enabled only while shifting
  logic tdo_bit;
  always_comb begin
    tdo_bit = byp_ff;
    if (sh_ir) begin
      tdo_bit = ir_sh_ff[0];
    end else if (sel_chain) begin
      tdo_bit = chain_sh_ff[0];
    end else if (sel_id) begin
      tdo_bit = id_sh_ff[0];
    end else if (sel_dbg) begin
      tdo_bit = dbg_sh_ff[0];
    end
  end

  always_ff @(negedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= tdo_bit;
      tdo_oe <= sh_ir | sh_dr;
    end
  end

  // core domain: swd pin routing
  logic swd_c1_ff;
  logic swd_c2_ff;
  logic usb_c1_ff;
  logic usb_c2_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      swd_c1_ff   <= 1'b0;
      swd_c2_ff   <= 1'b0;
      usb_c1_ff   <= 1'b0;
      usb_c2_ff   <= 1'b0;
      swd_gpio_en <= 1'b0;
      swd_usb_en  <= 1'b0;
    end else begin
      swd_c1_ff   <= swd_sel;
      swd_c2_ff   <= swd_c1_ff;
      usb_c1_ff   <= swd_usb_sel;
      usb_c2_ff   <= usb_c1_ff;
      swd_gpio_en <= swd_c2_ff & ~usb_c2_ff;
      swd_usb_en  <= swd_c2_ff & usb_c2_ff;
    end
  end

  // core domain: debug access port bridge
  logic                   req_c1_ff;
  logic                   req_c2_ff;
  logic                   req_c3_ff;
  jtag_tc_pkg::dbg_state_t dbg_state_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_c1_ff <= 1'b0;
      req_c2_ff <= 1'b0;
      req_c3_ff <= 1'b0;
    end else begin
      req_c1_ff <= req_tgl_ff;
      req_c2_ff <= req_c1_ff;
      req_c3_ff <= req_c2_ff;
    end
  end

  assign dbg_req_valid = (dbg_state_ff == jtag_tc_pkg::DB_REQ);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dbg_state_ff <= jtag_tc_pkg::DB_IDLE;
      dbg_rnw      <= 1'b0;
      dbg_addr     <= '0;
      dbg_wdata    <= '0;
      rsp_data_ff  <= '0;
      ack_tgl_ff   <= 1'b0;
    end else begin
      case (dbg_state_ff)
        jtag_tc_pkg::DB_IDLE: begin
          if (req_c2_ff ^ req_c3_ff) begin
            dbg_wdata    <= dbg_hold_ff[jtag_tc_pkg::DBG_DATA_W-1:0];
            dbg_rnw      <= dbg_hold_ff[jtag_tc_pkg::DBG_DATA_W];
            dbg_addr     <= dbg_hold_ff[jtag_tc_pkg::DBG_DR_W-1 -: jtag_tc_pkg::DBG_ADDR_W];
            dbg_state_ff <= jtag_tc_pkg::DB_REQ;
          end
        end
        jtag_tc_pkg::DB_REQ: begin
          if (dbg_req_ready) begin
            dbg_state_ff <= jtag_tc_pkg::DB_RSP;
          end
        end
        jtag_tc_pkg::DB_RSP: begin
          if (dbg_rsp_valid) begin
            rsp_data_ff  <= dbg_rdata;
            ack_tgl_ff   <= ~ack_tgl_ff;
            dbg_state_ff <= jtag_tc_pkg::DB_IDLE;
          end
        end
        default: begin
          dbg_state_ff <= jtag_tc_pkg::DB_IDLE;
        end
      endcase
    end
  end
endmodule : jtag_tap_test_controller

/* verification/jtag_tc_props.sv */
/*
  port checker for the tap test controller.
  assumes it is bound onto the controller; rstn resets both clock domains.
*/
module jtag_tc_props #(
  parameter int unsigned NUM_PINS = 8
) (
  input wire logic                core_clk,
  input wire logic                rstn,
  input wire logic                tck,
  input wire logic                tms,
  input wire logic                tdo_oe,
  input wire logic                swd_sel,
  input wire logic                swd_usb_sel,
  input wire logic                swd_gpio_en,
  input wire logic                swd_usb_en,
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_oe,
  input wire logic [NUM_PINS-1:0] core_in,
  input wire logic                test_mode,
  input wire logic                dbg_req_valid,
  input wire logic                dbg_req_ready,
  input wire logic                dbg_rnw,
  input wire logic [1:0]          dbg_addr,
  input wire logic [31:0]         dbg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  AST_REQ_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
    dbg_req_valid && !dbg_req_ready |=> dbg_req_valid
    && $stable({dbg_rnw, dbg_addr, dbg_wdata})) else $error("request dropped or changed");
  AST_REQ_DONE: assert property (@(posedge core_clk) disable iff (!rstn)
    dbg_req_valid && dbg_req_ready |=> !dbg_req_valid) else $error("request not retired");
  AST_PADS_NORMAL: assert property (@(posedge core_clk) disable iff (!rstn)
    !test_mode |-> pad_out == core_out && pad_oe == core_oe) else $error("pads not functional");
  AST_CORE_IN: assert property (@(posedge core_clk) disable iff (!rstn)
    !test_mode |-> core_in == pad_in) else $error("core input not from pads");
  AST_SWD_USB: assert property (@(posedge core_clk) disable iff (!rstn)
    (swd_sel && swd_usb_sel) [*4] |-> swd_usb_en && !swd_gpio_en) else $error("usb route wrong");
  AST_SWD_GPIO: assert property (@(posedge core_clk) disable iff (!rstn)
    (swd_sel && !swd_usb_sel) [*4] |-> swd_gpio_en && !swd_usb_en) else $error("gpio route wrong");
  AST_SWD_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
    (!swd_sel) [*4] |-> !swd_gpio_en && !swd_usb_en) else $error("swd route while jtag");
  AST_SWD_PARK: assert property (@(posedge tck) disable iff (!rstn)
    swd_sel [*5] |-> !tdo_oe) else $error("tap not parked");
  AST_TMS_RESET: assert property (@(posedge tck) disable iff (!rstn)
    tms [*5] |-> ##2 !test_mode && !tdo_oe) else $error("five tms highs did not reset");
  AST_SHIFT_ENTRY: assert property (@(posedge tck) disable iff (!rstn)
    $rose(tdo_oe) |-> !$past(tms)) else $error("shift entered with tms high");
  AST_SHIFT_EXIT: assert property (@(posedge tck) disable iff (!rstn)
    $fell(tdo_oe) |-> $past(tms)) else $error("shift left with tms low");
endmodule : jtag_tc_props

bind jtag_tap_test_controller jtag_tc_props #(.NUM_PINS(NUM_PINS)) u_props (
  .core_clk, .rstn, .tck, .tms, .tdo_oe, .swd_sel, .swd_usb_sel, .swd_gpio_en,
  .swd_usb_en, .pad_in, .pad_out, .pad_oe, .core_out, .core_oe, .core_in, .test_mode,
  .dbg_req_valid, .dbg_req_ready, .dbg_rnw, .dbg_addr, .dbg_wdata
);

/* verification/dbg_resp_model.sv */
/*
  debug access port responder behind the controller.
  assumes the request stays valid until ready; slow widens the wait.
*/
module dbg_resp_model #(
  parameter logic [31:0] RDATA = 32'h0bad_cafe
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire logic        dbg_req_valid,
  input  wire logic        dbg_rnw,
  input  wire logic [1:0]  dbg_addr,
  input  wire logic [31:0] dbg_wdata,
  output logic             dbg_req_ready,
  output logic             dbg_rsp_valid,
  output logic [31:0]      dbg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [34:0] got;
  logic        pend;
  int unsigned cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dbg_req_ready <= 1'b0;
      dbg_rsp_valid <= 1'b0;
      dbg_rdata     <= '0;
      pend          <= 1'b0;
      cnt           <= 0;
      got           <= '0;
    end else begin
      dbg_req_ready <= 1'b0;
      dbg_rsp_valid <= 1'b0;
      dbg_rdata     <= ~dbg_rdata;
      if (dbg_req_valid && !dbg_req_ready && !pend) begin
        cnt <= cnt + 1;
        if (cnt >= (slow ? 40 : 1)) begin
          dbg_req_ready <= 1'b1;
          pend          <= 1'b1;
          cnt           <= 0;
          got           <= {dbg_addr, dbg_rnw, dbg_wdata};
        end
      end else if (pend && !dbg_req_ready) begin
        pend          <= 1'b0;
        dbg_rsp_valid <= 1'b1;
        dbg_rdata     <= RDATA;
      end
    end
  end
endmodule : dbg_resp_model

/* verification/jtag_tap_test_controller_tb_top.sv */
/*
  testbench for the tap test controller: the bench acts as jtag host.
  assumes tck stops between scans and a responder model on the debug port.
*/
module jtag_tap_test_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NP   = 8;
  localparam logic [31:0] ID_V = 32'h1357_9bdf;  // arbitrary value
  localparam logic [31:0] RD_V = 32'h0bad_cafe;
  logic          core_clk = 1'b0;
  logic          rstn = 1'b0;
  logic          tck = 1'b0;
  logic          tms = 1'b1;
  logic          tdi = 1'b0;
  logic          trst_n = 1'b1;
  logic          swd_sel = 1'b0;
  logic          swd_usb_sel = 1'b0;
  logic          slow = 1'b0;
  logic [NP-1:0] pad_in = '0;
  logic [NP-1:0] core_out = '0;
  logic [NP-1:0] core_oe = '0;
  logic [NP-1:0] pad_out, pad_oe, core_in;
  logic          tdo, tdo_oe, swd_gpio_en, swd_usb_en, test_mode, last_q;
  logic          dbg_req_valid, dbg_req_ready, dbg_rnw, dbg_rsp_valid;
  logic [1:0]    dbg_addr;
  logic [31:0]   dbg_wdata, dbg_rdata;
  logic [63:0]   so;
  int            mismatches = 0;
  int            cmp_count = 0;
  int            cyc = 0;
  always #4 core_clk = ~core_clk;

  jtag_tap_test_controller #(.NUM_PINS(NP), .ID_VALUE(ID_V)) dut (
    .core_clk, .rstn, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe, .swd_sel,
    .swd_usb_sel, .swd_gpio_en, .swd_usb_en, .pad_in, .pad_out, .pad_oe, .core_out,
    .core_oe, .core_in, .test_mode, .dbg_req_valid, .dbg_req_ready, .dbg_rnw,
    .dbg_addr, .dbg_wdata, .dbg_rsp_valid, .dbg_rdata
  );
  dbg_resp_model #(.RDATA(RD_V)) p (
    .core_clk, .rstn, .slow, .dbg_req_valid, .dbg_rnw, .dbg_addr, .dbg_wdata,
    .dbg_req_ready, .dbg_rsp_valid, .dbg_rdata
  );

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input logic t, input logic d);
    tms <= t;
    tdi <= d;
    #20 last_q = tdo;
    tck = 1'b1;
    #40 tck = 1'b0;
    #20;
  endtask : tick
  task automatic scan(input logic ir, input int n, input logic [63:0] din);
    tick(1'b1, 1'b0);
    if (ir) tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    so = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      so[i] = last_q;
    end
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask : scan
  task automatic ld_ir(input logic [3:0] op);
    scan(1'b1, 4, {60'h0, op});
  endtask : ld_ir
  task automatic tap_rst();
    repeat (5) tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask : tap_rst
  function automatic logic [63:0] mk(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] c);
    mk = '0;
    for (int i = 0; i < 8; i++) mk[3*i +: 3] = {c[i], b[i], a[i]};
  endfunction : mk

  task automatic t_id();
    chk("tdo_oe", 1'b0, tdo_oe);
    tap_rst();
    ld_ir(jtag_tc_pkg::OP_EXTEST);
    chk("test_mode", 1'b1, test_mode);
    @(posedge core_clk);
    trst_n <= 1'b0;
    @(posedge core_clk);
    trst_n <= 1'b1;
    chk("trst_mode", 1'b0, test_mode);
    tick(1'b0, 1'b0);
    ld_ir(jtag_tc_pkg::OP_EXTEST);
    chk("test_mode", 1'b1, test_mode);
    tap_rst();
    scan(1'b0, 32, '0);
    chk("idcode", ID_V, so);
    chk("test_mode", 1'b0, test_mode);
    $display("test id done");
  endtask : t_id
  task automatic t_byp();
    for (int k = 0; k < 2; k++) begin
      ld_ir(k ? 4'h5 : jtag_tc_pkg::OP_BYPASS);
      chk("ir_capture", jtag_tc_pkg::IR_CAPTURE, so);
      scan(1'b0, 8, 64'ha5);
      chk("bypass", 64'h4a, so);
    end
    $display("test bypass done");
  endtask : t_byp
  task automatic t_chain();
    @(posedge core_clk);
    pad_in   <= 8'h3c;
    core_out <= 8'h96;
    core_oe  <= 8'hf0;
    for (int k = 0; k < 2; k++) begin
      ld_ir(k ? jtag_tc_pkg::OP_PRELOAD : jtag_tc_pkg::OP_SAMPLE);
      scan(1'b0, 24, '0);
      chk("chain", mk(8'h3c, 8'h96, 8'hf0), so);
      chk("test_mode", 1'b0, test_mode);
    end
    scan(1'b0, 24, mk(8'h00, 8'h5a, 8'hff));
    ld_ir(jtag_tc_pkg::OP_EXTEST);
    chk("pad_out", 8'h5a, pad_out);
    chk("pad_oe", 8'hff, pad_oe);
    scan(1'b0, 24, mk(8'h00, 8'h5a, 8'hff));
    chk("ext_cap", mk(8'h3c, 8'h96, 8'hf0), so);
    ld_ir(jtag_tc_pkg::OP_INTEST);
    scan(1'b0, 24, mk(8'hc3, 8'h00, 8'h00));
    chk("core_in", 8'hc3, core_in);
    scan(1'b0, 24, mk(8'hc3, 8'h00, 8'h00));
    chk("int_cap", mk(8'h00, 8'h96, 8'hf0), so);
    tap_rst();
    $display("test chain done");
  endtask : t_chain
  task automatic t_dbg();
    @(posedge core_clk);
    slow <= 1'b1;
    ld_ir(jtag_tc_pkg::OP_DBG);
    scan(1'b0, 35, {2'h1, 1'b1, 32'h1234_abcd});
    scan(1'b0, 35, {2'h1, 1'b1, 32'h1234_abcd});
    chk("ack_wait", {jtag_tc_pkg::ACK_WAIT, 32'h0}, so);
    repeat (12) tick(1'b0, 1'b0);
    chk("request", {2'h1, 1'b1, 32'h1234_abcd}, p.got);
    @(posedge core_clk);
    slow <= 1'b0;
    scan(1'b0, 35, {2'h2, 1'b0, 32'h0f0f_1111});
    chk("ack_ok", {jtag_tc_pkg::ACK_OK, RD_V}, so);
    repeat (6) tick(1'b0, 1'b0);
    chk("request", {2'h2, 1'b0, 32'h0f0f_1111}, p.got);
    $display("test debug done");
  endtask : t_dbg
  task automatic t_swd();
    ld_ir(jtag_tc_pkg::OP_BYPASS);
    @(posedge core_clk);
    swd_sel     <= 1'b1;
    swd_usb_sel <= 1'b1;
    repeat (5) tick(1'b0, 1'b0);
    chk("usb_en", 2'b10, {swd_usb_en, swd_gpio_en});
    @(posedge core_clk);
    swd_usb_sel <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("gpio_en", 2'b01, {swd_usb_en, swd_gpio_en});
    swd_sel <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("swd_off", 2'b00, {swd_usb_en, swd_gpio_en});
    repeat (3) tick(1'b0, 1'b0);
    scan(1'b0, 32, '0);
    chk("parked_id", ID_V, so);
    $display("test swd done");
  endtask : t_swd

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_id();
    t_byp();
    t_chain();
    t_dbg();
    t_swd();
    give_verdict();
  end
endmodule : jtag_tap_test_controller_tb_top
